// ===== logic/slc_codec.sv
/*
 * Frame codec top: APB registers, transmit encoder with balance inversion and
 * serialiser, receive aligner and decoder, and the link state machine.
 * Assumes serial pins run at pclk divided by BIT_DIV on both ends, and
 * that handshake, clear and ready pins are asynchronous levels.
 */
`default_nettype none
module slc_codec
#(
    parameter int unsigned    BIT_DIV_P = slc_pkg::BIT_DIV,
    parameter logic    [19:0] FILL_A_P  = slc_pkg::FILL_A,
    parameter logic    [19:0] FILL_B_P  = slc_pkg::FILL_B
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_register_clear_n,
    input  wire logic        handshake_clear_a_n,
    input  wire logic        handshake_clear_b_n,
    input  wire logic        ready_request_input,
    input  wire logic        primary_serial_rx,
    input  wire logic        loopback_serial_rx,
    output logic             primary_serial_tx,
    output logic             loopback_serial_tx,
    output logic             loopback_tx_oe,
    output logic             polarity_flipped,
    output logic             tx_word_clock_out,
    output logic             tx_pll_lock_indicator,
    output logic             word_clock_out,
    output logic      [19:0] rx_data,
    output logic             word_valid_n,
    output logic             ctrl_word_valid_n,
    output logic             extra_user_bit,
    output logic             odd_half,
    output logic             link_state_hi,
    output logic             link_state_lo,
    output logic             link_up_n
);
    import slc_pkg::*;

    logic [5:0]         ctrl_r;
    logic [19:0]        txd_r;
    logic [2:0]         txk_r;
    logic [5:0]         pins_s;
    logic               wide;
    logic               xbit;
    logic               loop_en;
    logic               txclr;
    logic               hs_clear;
    logic               acc_phase;
    logic               wr_en;
    logic [4:0]         flen;
    logic [7:0]         bdiv_r;
    logic               bit_tick;
    logic [4:0]         tcnt_r;
    logic               tx_bnd;
    logic               half_r;
    logic [23:0]        frame_r;
    logic [23:0]        cap_f;
    logic [1:0]         cap_t;
    logic [19:0]        cap_d;
    logic [23:0]        tx_sh_r;
    logic signed [7:0]  dacc_r;
    logic signed [6:0]  disp;
    logic               tx_inv;
    logic [4:0]         rcnt_r;
    logic [23:0]        rx_sh_r;
    logic [23:0]        rx_nxt;
    logic               rx_bnd;
    logic [3:0]         rc;
    logic [3:0]         rc_fix;
    logic [19:0]        rd;
    logic [19:0]        rd_fix;
    logic               rinv;
    logic               rbad;
    logic [19:0]        dec_d_r;
    logic [1:0]         dec_t_r;
    logic               dec_inv_r;
    logic               rx_inv_r;
    logic [6:0]         wcnt_r;
    slc_link_t          st_r;

    assign wide     = ctrl_r[C_WIDE];
    assign xbit     = ctrl_r[C_XBIT];
    assign loop_en  = ctrl_r[C_LOOP];
    assign txclr    = ~pins_s[0];
    assign hs_clear = ~pins_s[1] & ~pins_s[2];
    assign flen     = wide ? LEN_W : LEN_N;

    // pins: tx clear, handshake a/b, ready, rx primary, rx loopback
    slc_sync #(.W(6)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({loopback_serial_rx, primary_serial_rx, ready_request_input,
                   handshake_clear_b_n, handshake_clear_a_n, tx_register_clear_n}),
        .dout    (pins_s)
    );

    // apb: one wait state, write and read data settle at pready
    assign acc_phase = psel & penable & ~pready;
    assign wr_en     = psel & penable & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc_phase;
            pslverr <= 1'b0;
            if (acc_phase) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    A_CTRL:   prdata <= {26'h0, ctrl_r};
                    A_TXDATA: prdata <= {12'h0, txd_r};
                    A_TXCMD:  prdata <= {29'h0, txk_r};
                    A_STATUS: prdata <= {26'h0, tx_pll_lock_indicator, rx_inv_r,
                                         link_up_n, st_r};
                    A_RXDATA: prdata <= {12'h0, rx_data};
                    A_RXCTL:  prdata <= {27'h0, odd_half, extra_user_bit,
                                         ctrl_word_valid_n, word_valid_n,
                                         polarity_flipped};
                    default:  pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_en && paddr == A_CTRL) begin
            ctrl_r <= pwdata[5:0];
        end
    end

    // transmit word and command; valid bits return idle once captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_r <= 20'h00000;
            txk_r <= TXK_RST;
        end else if (txclr) begin
            txd_r <= 20'h00000;
            txk_r <= TXK_RST;
        end else begin
            if (wr_en && paddr == A_TXDATA) begin
                txd_r <= pwdata[19:0];
            end
            if (wr_en && paddr == A_TXCMD) begin
                txk_r <= pwdata[2:0];
            end else if (tx_bnd) begin
                txk_r <= txk_r | 3'h3;
            end
        end
    end

    // bit rate divider shared by both directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdiv_r <= 8'h00;
        end else if (bit_tick) begin
            bdiv_r <= 8'h00;
        end else begin
            bdiv_r <= bdiv_r + 8'h01;
        end
    end
    assign bit_tick = (bdiv_r == 8'(BIT_DIV_P - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_r <= 5'd0;
        end else if (txclr) begin
            tcnt_r <= 5'd0;
        end else if (bit_tick) begin
            tcnt_r <= tx_bnd ? 5'd0 : tcnt_r + 5'd1;
        end
    end
    assign tx_bnd = bit_tick & (tcnt_r == flen - 5'd1);

    // frame selection and control field
    always_comb begin
        if (!txk_r[K_CWV]) begin
            cap_t = T_CTRL;
            cap_d = txd_r & (wide ? M_CTRL_W : M_CTRL_N);
        end else if (!txk_r[K_WV]) begin
            cap_t = T_DATA0 | {1'b0, xbit ? txk_r[K_XU] : half_r};
            cap_d = txd_r & (wide ? M_DATA_W : M_DATA_N);
        end else begin
            cap_t = T_FILL;
            cap_d = ((ctrl_r[C_FAUTO] ? link_state_hi : ctrl_r[C_FSEL]) ? FILL_B_P
                     : FILL_A_P) & (wide ? M_DATA_W : M_DATA_N);
        end
        cap_f = wide ? {MT_NORM, cap_t, cap_d}
                     : {MT_NORM, cap_t, cap_d[15:0], 4'h0};
    end

    slc_disparity u_disp (
        .frame (frame_r),
        .wide  (wide),
        .disp  (disp)
    );

    assign tx_inv = (disp > 7'sd0 && dacc_r > 8'sd0)
                  || (disp < 7'sd0 && dacc_r < 8'sd0);

    // capture now, shift out the previous capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_r          <= 24'h000000;
            tx_sh_r          <= 24'h000000;
            dacc_r           <= 8'sd0;
            half_r           <= 1'b0;
            polarity_flipped <= 1'b0;
        end else if (txclr) begin
            frame_r          <= 24'h000000;
            tx_sh_r          <= 24'h000000;
            dacc_r           <= 8'sd0;
            half_r           <= 1'b0;
            polarity_flipped <= 1'b0;
        end else if (tx_bnd) begin
            frame_r          <= cap_f;
            half_r           <= ctrl_r[C_SPLIT] ? ~half_r : 1'b0;
            tx_sh_r          <= tx_inv ? frame_r ^ (wide ? M_FR_W : M_FR_N)
                                       : frame_r;
            dacc_r           <= tx_inv ? dacc_r - 8'(disp)
                                       : dacc_r + 8'(disp);
            polarity_flipped <= tx_inv;
        end else if (bit_tick) begin
            tx_sh_r <= {tx_sh_r[22:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_serial_tx     <= 1'b0;
            loopback_serial_tx    <= 1'b0;
            loopback_tx_oe        <= 1'b0;
            tx_word_clock_out     <= 1'b0;
            tx_pll_lock_indicator <= 1'b0;
        end else begin
            primary_serial_tx     <= tx_sh_r[23];
            loopback_serial_tx    <= loop_en & tx_sh_r[23];
            loopback_tx_oe        <= loop_en;
            tx_word_clock_out     <= tx_bnd;
            if (txclr) begin
                tx_pll_lock_indicator <= 1'b0;
            end else if (tx_bnd) begin
                tx_pll_lock_indicator <= 1'b1;
            end
        end
    end

    // receive: shift in, decode on frame boundary
    assign rx_nxt = {rx_sh_r[22:0], loop_en ? pins_s[5] : pins_s[4]};
    assign rx_bnd = bit_tick & (rcnt_r == flen - 5'd1);

    always_comb begin
        rc     = wide ? rx_nxt[23:20] : rx_nxt[19:16];
        rd     = wide ? rx_nxt[19:0] : {4'h0, rx_nxt[15:0]};
        rinv   = ~rc[3];
        rbad   = (rc[3] == rc[2]);
        rc_fix = rinv ? ~rc : rc;
        rd_fix = rinv ? ~rd & (wide ? M_DATA_W : M_DATA_N) : rd;
    end

    // a missing master transition holds the count: hunt one bit later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r  <= 5'd0;
            rx_sh_r <= 24'h000000;
        end else if (bit_tick) begin
            rx_sh_r <= rx_nxt;
            if (rx_bnd) begin
                rcnt_r <= rbad ? rcnt_r : 5'd0;
            end else begin
                rcnt_r <= rcnt_r + 5'd1;
            end
        end
    end

    // stage one: decoded frame held for a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_d_r   <= 20'h00000;
            dec_t_r   <= T_FILL;
            dec_inv_r <= 1'b0;
        end else if (rx_bnd) begin
            dec_d_r   <= rd_fix;
            dec_t_r   <= rbad ? T_FILL : rc_fix[1:0];
            dec_inv_r <= rinv;
        end
    end

    // stage two: user outputs, two frames after arrival
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data           <= 20'h00000;
            word_valid_n      <= 1'b1;
            ctrl_word_valid_n <= 1'b1;
            extra_user_bit    <= 1'b0;
            odd_half          <= 1'b0;
            rx_inv_r          <= 1'b0;
            link_up_n         <= 1'b1;
            word_clock_out    <= 1'b0;
        end else begin
            word_clock_out <= rx_bnd;
            if (rx_bnd) begin
                rx_data           <= dec_d_r;
                rx_inv_r          <= dec_inv_r;
                ctrl_word_valid_n <= ~(dec_t_r == T_CTRL);
                word_valid_n      <= dec_t_r[1];
                link_up_n         <= ~pins_s[3];
                if (!dec_t_r[1]) begin
                    if (xbit) begin
                        extra_user_bit <= dec_t_r[0];
                    end else begin
                        odd_half <= dec_t_r[0];
                    end
                end
            end
        end
    end

    // link state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= ST_WAIT;
            wcnt_r <= 7'd0;
        end else if (hs_clear) begin
            st_r   <= ST_WAIT;
            wcnt_r <= 7'd0;
        end else if (rx_bnd) begin
            if (rbad) begin
                st_r   <= ST_WAIT;
                wcnt_r <= 7'd0;
            end else begin
                case (st_r)
                    ST_WAIT: begin
                        wcnt_r <= wcnt_r + 7'd1;
                        if (wcnt_r == WAIT_FRAMES) begin
                            st_r <= ST_TRAIN;
                        end
                    end
                    ST_TRAIN: begin
                        if (rc_fix[1:0] != T_FILL
                            || rd_fix == (FILL_B_P & (wide ? M_DATA_W : M_DATA_N))) begin
                            st_r <= ST_ACTIVE;
                        end
                    end
                    ST_ACTIVE: st_r <= ST_ACTIVE;
                    default:   st_r <= ST_WAIT;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_state_hi <= 1'b0;
            link_state_lo <= 1'b0;
        end else begin
            link_state_hi <= (st_r == ST_ACTIVE);
            link_state_lo <= (st_r == ST_TRAIN);
        end
    end
endmodule : slc_codec
`default_nettype wire

// ===== logic/slc_pkg.sv
/*
 * Constants, register map and state type for the serial link frame codec.
 * Assumes a single 50 MHz pclk domain and an APB register bus.
 */
// Summary of operation
// - control valid low sends the low data bits as a control word
// - control valid high, word valid low sends a data frame
// - neither valid low sends fill frames to hold balance and lock
// - fill select picks fill pattern a or b, or link_state_hi picks when fill auto is set
// - four control bits carry master transition and the frame type
// - data field carries parallel data or the chosen fill pattern
// - transmit register clear low resets all transmit registers
// - four control bits join 16 or 20 data bits and shift out
// - frames are inverted to keep the line balanced; polarity_flipped marks them
// - serial data always on primary; loopback output only with loop enabled
// - receiver takes primary input, or loopback input when loop enabled
// - receiver aligns its word clock to the master transition each frame
// - receiver forms 20 or 24 bit words, top four bits are control
// - control decoder finds type and inversion, feeds the state machine
// - receiver marks control frames, data frames, and neither for fill
// - extra bit mode restores user bit, else marks even and odd halves
// - both handshake clears low reset the link state machine
// - ready request is resampled on the word clock as link_up_n
// - transmit word clock output runs at the word rate except while transmit register clear is low
// - first serial bit leaves one word cycle after capture
// - serial rate is 20 or 24 bits per frame
// - state 0 after reset or error, state 1 after 128 frames
// - receive outputs update two frames after the serial frame
`default_nettype none
package slc_pkg;
    localparam logic [7:0]  A_CTRL   = 8'h00;
    localparam logic [7:0]  A_TXDATA = 8'h04;
    localparam logic [7:0]  A_TXCMD  = 8'h08;
    localparam logic [7:0]  A_STATUS = 8'h0C;
    localparam logic [7:0]  A_RXDATA = 8'h10;
    localparam logic [7:0]  A_RXCTL  = 8'h14;
    localparam int unsigned C_WIDE   = 0;
    localparam int unsigned C_XBIT   = 1;
    localparam int unsigned C_SPLIT  = 2;
    localparam int unsigned C_LOOP   = 3;
    localparam int unsigned C_FSEL   = 4;
    localparam int unsigned C_FAUTO  = 5;
    localparam logic [5:0]  CTRL_RST = 6'h00;
    localparam int unsigned K_WV     = 0;
    localparam int unsigned K_CWV    = 1;
    localparam int unsigned K_XU     = 2;
    localparam logic [2:0]  TXK_RST  = 3'h3;
    localparam logic [4:0]  LEN_N    = 5'd20;
    localparam logic [4:0]  LEN_W    = 5'd24;
    localparam logic [1:0]  MT_NORM  = 2'h2;
    localparam logic [1:0]  T_DATA0  = 2'h0;
    localparam logic [1:0]  T_CTRL   = 2'h2;
    localparam logic [1:0]  T_FILL   = 2'h3;
    localparam logic [19:0] FILL_A   = 20'h3C3C3;
    localparam logic [19:0] FILL_B   = 20'hC3C3C;
    localparam logic [19:0] M_CTRL_W = 20'h3FFFF;
    localparam logic [19:0] M_CTRL_N = 20'h03FFF;
    localparam logic [19:0] M_DATA_N = 20'h0FFFF;
    localparam logic [19:0] M_DATA_W = 20'hFFFFF;
    localparam logic [23:0] M_FR_W   = 24'hFFFFFF;
    localparam logic [23:0] M_FR_N   = 24'hFFFFF0;
    localparam logic [6:0]  WAIT_FRAMES = 7'd127;
    localparam int unsigned BIT_DIV  = 2;
    typedef enum logic [2:0] {
        ST_WAIT   = 3'b001,
        ST_TRAIN  = 3'b010,
        ST_ACTIVE = 3'b100
    } slc_link_t;
endpackage : slc_pkg
`default_nettype wire

// ===== logic/slc_sync.sv
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; no word coherency across bits.
 */
`default_nettype none
module slc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : slc_sync
`default_nettype wire

// ===== logic/slc_disparity.sv
/*
 * Disparity of a left-aligned frame: ones minus zeros over the used bits.
 * Assumes unused low bits of a narrow frame are masked off by the caller.
 */
`default_nettype none
module slc_disparity (
    input  wire logic        [23:0] frame,
    input  wire logic               wide,
    output logic signed      [6:0]  disp
);
    logic [4:0] ones;

    always_comb begin
        ones = 5'd0;
        for (int i = 0; i < 24; i++) begin
            ones = ones + {4'd0, frame[i]};
        end
        disp = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, wide ? 5'd24 : 5'd20});
    end
endmodule : slc_disparity
`default_nettype wire

// ===== tb/slc_codec_chk.sv
/* Port checker for slc_codec, attached by bind.
   Assumes one pclk domain and the design's bit divider parameter. */
`default_nettype none
module slc_codec_chk #(
    parameter int unsigned BIT_DIV_P = 2
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        tx_register_clear_n,
    input wire logic        handshake_clear_a_n,
    input wire logic        handshake_clear_b_n,
    input wire logic        primary_serial_tx,
    input wire logic        loopback_serial_tx,
    input wire logic        loopback_tx_oe,
    input wire logic        polarity_flipped,
    input wire logic        tx_word_clock_out,
    input wire logic        word_clock_out,
    input wire logic [19:0] rx_data,
    input wire logic        link_state_hi,
    input wire logic        link_state_lo,
    input wire logic        link_up_n
);
    logic [7:0] tcnt_r;
    logic       seen_r;
    logic [7:0] wcnt_r;
    logic       txoff;
    assign txoff = !presetn || !tx_register_clear_n;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since last tx frame, frames seen while waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_r <= 8'h00;
            seen_r <= 1'b0;
            wcnt_r <= 8'h00;
        end else begin
            tcnt_r <= tx_word_clock_out ? 8'h00 : tcnt_r + 8'h01;
            seen_r <= tx_register_clear_n & (seen_r | tx_word_clock_out);
            if (link_state_hi | link_state_lo | ~(handshake_clear_a_n | handshake_clear_b_n)) begin
                wcnt_r <= 8'h00;
            end else if (word_clock_out && wcnt_r != 8'hFF) begin
                wcnt_r <= wcnt_r + 8'h01;
            end
        end
    end
    property p_loop_off;
        !loopback_tx_oe && !$past(loopback_tx_oe) |-> !loopback_serial_tx;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loopback out active while off");
    property p_loop_copy;
        loopback_tx_oe && $past(loopback_tx_oe) |-> loopback_serial_tx == primary_serial_tx;
    endproperty
    a_loop_copy: assert property (p_loop_copy) else $error("loopback out differs");
    property p_tx_period;
        disable iff (txoff)
        tx_word_clock_out && seen_r |-> tcnt_r == 20 * BIT_DIV_P - 1 || tcnt_r == 24 * BIT_DIV_P - 1;
    endproperty
    a_tx_period: assert property (p_tx_period) else $error("tx frame length wrong");
    property p_bit_hold;
        disable iff (txoff)
        $changed(primary_serial_tx) |=> $stable(primary_serial_tx);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("serial bit too short");
    property p_flip_frame;
        disable iff (txoff)
        $changed(polarity_flipped) |-> tx_word_clock_out || $past(tx_word_clock_out);
    endproperty
    a_flip_frame: assert property (p_flip_frame) else $error("flip mark off frame");
    property p_rx_frame;
        $changed(rx_data) |-> word_clock_out || $past(word_clock_out);
    endproperty
    a_rx_frame: assert property (p_rx_frame) else $error("rx data off frame");
    property p_linkup_frame;
        $changed(link_up_n) |-> word_clock_out || $past(word_clock_out);
    endproperty
    a_linkup_frame: assert property (p_linkup_frame) else $error("link up off frame");
    property p_wait_frames;
        $rose(link_state_lo) && !$past(link_state_hi) |-> wcnt_r >= 8'd127;
    endproperty
    a_wait_frames: assert property (p_wait_frames) else $error("train too early");
    property p_hs_clear;
        (!handshake_clear_a_n && !handshake_clear_b_n) [*4] |=> !link_state_hi && !link_state_lo;
    endproperty
    a_hs_clear: assert property (p_hs_clear) else $error("state not cleared");
endmodule : slc_codec_chk
bind slc_codec slc_codec_chk #(.BIT_DIV_P(BIT_DIV_P)) u_chk (.*);
`default_nettype wire

// ===== tb/slc_peer.sv
/* Far side of the serial line: cable back to our receiver plus ready pin.
   Assumes the peer echoes our stream one pclk later. */
`default_nettype none
module slc_peer (
    input  wire logic pclk,
    input  wire logic line_cut,
    input  wire logic tx_line,
    input  wire logic link_state_hi,
    output var  logic rx_line,
    output var  logic ready_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {rx_line, ready_req} = 2'b00;
    // a cut cable shows a toggling level, never the last bit
    always @(posedge pclk) begin
        rx_line <= line_cut ? ~rx_line : tx_line;
        ready_req <= link_state_hi;
    end
endmodule : slc_peer
`default_nettype wire

// ===== tb/serial_link_frame_codec_tb.sv
/* Self-checking bench for slc_codec with a line peer.
   Assumes 50 MHz pclk and APB register access. */
`default_nettype none
module serial_link_frame_codec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import slc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        tx_register_clear_n = 1, handshake_clear_a_n = 1, handshake_clear_b_n = 1;
    logic        ready_request_input, primary_serial_rx, loopback_serial_rx, err;
    logic        primary_serial_tx, loopback_serial_tx, loopback_tx_oe, polarity_flipped;
    logic        tx_word_clock_out, tx_pll_lock_indicator, word_clock_out, word_valid_n;
    logic [19:0] rx_data;
    logic        ctrl_word_valid_n, extra_user_bit, odd_half, link_state_hi, link_state_lo;
    logic        link_up_n, line_cut = 0, tgl = 0, flip_seen = 0;
    int          fail_count = 0, n_checks = 0, cyc = 0, t0;
    slc_codec #(.BIT_DIV_P(2)) dut (.*);
    slc_peer peer (.pclk, .line_cut, .tx_line(primary_serial_tx), .link_state_hi,
        .rx_line(primary_serial_rx), .ready_req(ready_request_input));
    // released loopback line toggles
    assign loopback_serial_rx = loopback_tx_oe ? loopback_serial_tx : tgl;
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) begin
        tgl <= ~tgl;
        flip_seen <= flip_seen | (polarity_flipped === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            $display("unexpected %0t timeout", $time);
            results();
        end
    end
    task automatic ck(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : ck
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ck(n < 20, "no apb answer");
    endtask : apb
    task automatic wt(ref logic s, input logic v, input int lim, input string m);
        int n = 0;
        while (s !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        ck(n < lim, m);
    endtask : wt
    // write control under tx clear so no frame is cut, then let rx realign
    task automatic cfg(input logic [31:0] c);
        tx_register_clear_n <= 1'b0;
        apb(1'b1, A_CTRL, c);
        repeat (2) @(posedge pclk);
        ck(tx_pll_lock_indicator === 1'b0, "tx not cleared");
        tx_register_clear_n <= 1'b1;
        wt(tx_pll_lock_indicator, 1'b1, 200, "tx no restart");
        repeat (1500) @(posedge pclk);
    endtask : cfg
    task automatic t_word(input logic [19:0] d, input logic [2:0] k, input logic [19:0] m,
                          input logic xe);
        int n = 0;
        apb(1'b1, A_TXDATA, {12'h000, d});
        apb(1'b1, A_TXCMD, {29'h0, k});
        do begin
            apb(1'b0, A_TXCMD, 32'h0);
            n++;
        end while (rd[1:0] !== 2'b11 && n < 40);
        ck(n < 40, "frame not taken");
        if (k[1] === 1'b0) begin
            wt(ctrl_word_valid_n, 1'b0, 600, "no control frame");
        end else begin
            wt(word_valid_n, 1'b0, 600, "no data frame");
        end
        ck((rx_data & m) === (d & m), "rx data");
        if (xe) begin
            ck(extra_user_bit === k[2], "user bit");
        end
        wt(word_valid_n, 1'b1, 200, "valid stuck");
        wt(ctrl_word_valid_n, 1'b1, 200, "control stuck");
    endtask : t_word
    task automatic t_reset;
        ck(link_up_n === 1'b1 && word_valid_n === 1'b1 && ctrl_word_valid_n === 1'b1, "reset");
        apb(1'b0, A_CTRL, 32'h0);
        ck(rd === 32'h0, "ctrl reset");
        apb(1'b0, A_TXCMD, 32'h0);
        ck(rd === {29'h0, TXK_RST}, "txcmd reset");
        apb(1'b0, 8'h18, 32'h0);
        ck(err === 1'b1 && rd === 32'h0, "unmapped read");
        cfg(32'h0);
        ck(word_valid_n === 1'b1 && ctrl_word_valid_n === 1'b1, "idle not fill");
    endtask : t_reset
    task automatic t_words;
        t_word(20'hF1234, 3'b010, M_DATA_N, 1'b0);
        t_word(20'hA5A5A, 3'b000, M_CTRL_N, 1'b0);
        repeat (4) t_word(20'h0FFFF, 3'b010, M_DATA_N, 1'b0);
        ck(flip_seen, "no inverted frame");
        cfg(32'h3);
        t_word(20'hABCDE, 3'b110, M_DATA_W, 1'b1);
        t_word(20'h5A5A5, 3'b010, M_DATA_W, 1'b1);
        t_word(20'hFFFFF, 3'b000, M_CTRL_W, 1'b0);
        line_cut <= 1'b1;
        cfg(32'h8);
        ck(loopback_tx_oe === 1'b1, "loop enable");
        t_word(20'h03C5A, 3'b010, M_DATA_N, 1'b0);
        line_cut <= 1'b0;
        cfg(32'h0);
    endtask : t_words
    task automatic t_link;
        {handshake_clear_a_n, handshake_clear_b_n} <= 2'b00;
        repeat (8) @(posedge pclk);
        ck(link_state_hi === 1'b0 && link_state_lo === 1'b0, "state kept");
        {handshake_clear_a_n, handshake_clear_b_n} <= 2'b11;
        t0 = cyc;
        wt(link_state_lo, 1'b1, 8000, "no train");
        ck(cyc - t0 >= 127 * 40, "train early");
        apb(1'b1, A_CTRL, 32'h10);
        wt(link_state_hi, 1'b1, 800, "no active");
        wt(link_up_n, 1'b0, 400, "no link up");
        handshake_clear_a_n <= 1'b0;
        repeat (8) @(posedge pclk);
        ck(link_state_hi === 1'b1, "one clear reset state");
        handshake_clear_a_n <= 1'b1;
    endtask : t_link
    task automatic results;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_words();
        t_link();
        results();
    end
endmodule : serial_link_frame_codec_tb
`default_nettype wire
